/* include/asr_pkg.sv */
`default_nettype none

package asr_pkg;

    // core clock rate, used to turn times into cycle counts
    localparam int CORE_CLK_MHZ = 10;

    // analog settle time after leaving shutdown or after power-up
    localparam int SETTLE_TIME_US = 300;
    localparam int SETTLE_CYCLES = SETTLE_TIME_US * CORE_CLK_MHZ;

    // conversion_time, fixed by the filter
    localparam int CONV_TIME_US = 72700;
    localparam int CONV_CYCLES = CONV_TIME_US * CORE_CLK_MHZ;

    // result word layout, sent most significant bit first
    localparam int WORD_BITS = 24;
    localparam int UNDERFLOW_POS = 23;
    localparam int OVERFLOW_POS = 22;
    localparam int CODE_BITS = 22;

    // falling-edge counter on the serial clock
    localparam int FALL_CNT_W = 5;
    localparam logic [FALL_CNT_W-1:0] FALL_IDLE = 5'h00;
    localparam logic [FALL_CNT_W-1:0] FALL_LAST_BIT = 5'h18;

    // reset values
    localparam logic CS_IDLE_RST = 1'b1;
    localparam logic RDY_LATCH_RST = 1'b1;
    localparam logic SINGLE_RST = 1'b1;

    typedef enum logic [1:0] {
        ST_SHUTDOWN,
        ST_SETTLE,
        ST_CONVERT,
        ST_SLEEP
    } asr_state_t;

endpackage : asr_pkg

`default_nettype wire

/* src/asr_readout.sv */
`timescale 1ns/10ps
`default_nettype none

module asr_readout #(
    parameter int CONV_CYCLES_P = asr_pkg::CONV_CYCLES,
    parameter int SETTLE_CYCLES_P = asr_pkg::SETTLE_CYCLES,
    parameter int TIMER_W = 20
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic serial_clk,
    input wire logic chip_select_n,
    input wire logic overflow_low_flag,
    input wire logic overflow_high_flag,
    input wire logic [asr_pkg::CODE_BITS-1:0] filter_code,
    output logic data_out_ready_pin_o,
    output logic data_out_ready_pin_oe_n,
    output logic converting,
    output logic continuous_mode,
    output logic in_shutdown,
    output logic result_valid
);
    import asr_pkg::*;

    initial begin
        if (CONV_CYCLES_P < 1 || CONV_CYCLES_P > (2 ** TIMER_W)) begin
            $error("asr_readout: CONV_CYCLES_P does not fit the timer");
        end
        if (SETTLE_CYCLES_P < 1 || SETTLE_CYCLES_P > (2 ** TIMER_W)) begin
            $error("asr_readout: SETTLE_CYCLES_P does not fit the timer");
        end
    end

    localparam logic [TIMER_W-1:0] CONV_LOAD = TIMER_W'(CONV_CYCLES_P - 1);
    localparam logic [TIMER_W-1:0] SETTLE_LOAD = TIMER_W'(SETTLE_CYCLES_P - 1);

    // ---------------- link side, on the serial clock ----------------

    typedef struct packed {
        logic [FALL_CNT_W-1:0] falls;
    } asr_shift_t;

    typedef struct packed {
        logic start_tg;
        logic done_tg;
    } asr_event_t;

    asr_shift_t shift_q;
    asr_shift_t shift_d;
    asr_event_t event_q;
    asr_event_t event_d;
    logic shift_rst_n;

    // the frame's own select ends the transfer, even with the clock stopped
    assign shift_rst_n = reset_n & ~chip_select_n;

    always_comb begin
        shift_d = shift_q;
        event_d = event_q;
        if (shift_q.falls == FALL_LAST_BIT) begin
            // 25th fall: back to showing ready, word complete
            shift_d.falls = FALL_IDLE;
            event_d.done_tg = ~event_q.done_tg;
        end else begin
            // counts single clocks, no grouping into bytes
            shift_d.falls = shift_q.falls + 5'h01;
        end
        // a clock meant for another device on the bus starts no read
        if (shift_q.falls == FALL_IDLE && !chip_select_n) begin
            event_d.start_tg = ~event_q.start_tg;
        end
    end

    always_ff @(negedge serial_clk or negedge shift_rst_n) begin
        if (!shift_rst_n) begin
            shift_q <= '0;
        end else begin
            shift_q <= shift_d;
        end
    end

    // toggles survive select, so the core never misses an event
    always_ff @(negedge serial_clk or negedge reset_n) begin
        if (!reset_n) begin
            event_q <= '0;
        end else begin
            event_q <= event_d;
        end
    end

    // ---------------- core side ----------------

    typedef struct packed {
        asr_state_t state;
        logic [TIMER_W-1:0] timer;
        logic cs_prev;
        logic start_prev;
        logic done_prev;
        logic single;
        logic drop;
        logic ready;
        logic unread;
        logic reading;
        logic rdy_latch;
        logic pend;
        logic [WORD_BITS-1:0] word;
        logic [WORD_BITS-1:0] pend_word;
    } asr_core_t;

    asr_core_t core_q;
    asr_core_t core_d;

    logic [2:0] sync_raw;
    logic [2:0] sync_out;
    logic cs_s;
    logic start_s;
    logic done_s;
    logic cs_fall;
    logic cs_rise;
    logic start_ev;
    logic done_ev;
    logic [WORD_BITS-1:0] new_word;

    // select goes in inverted: a flop reset to zero then reads as deselected,
    // so no false select fall follows reset
    assign sync_raw = {~chip_select_n, event_q.start_tg, event_q.done_tg};

    asr_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk(core_clk),
        .rst_n(reset_n),
        .async_in(sync_raw),
        .sync_out(sync_out)
    );

    assign cs_s = ~sync_out[2];
    assign start_s = sync_out[1];
    assign done_s = sync_out[0];
    assign cs_fall = core_q.cs_prev & ~cs_s;
    assign cs_rise = ~core_q.cs_prev & cs_s;
    assign start_ev = start_s ^ core_q.start_prev;
    assign done_ev = done_s ^ core_q.done_prev;

    // two flags above a two's-complement code
    assign new_word = {overflow_low_flag, overflow_high_flag, filter_code};

    always_comb begin
        core_d = core_q;
        core_d.cs_prev = cs_s;
        core_d.start_prev = start_s;
        core_d.done_prev = done_s;

        if (start_ev) begin
            core_d.reading = 1'b1;
        end

        if (done_ev) begin
            core_d.reading = 1'b0;
            core_d.ready = 1'b0;
            if (core_q.pend) begin
                // newest held-off result replaces the one just read
                core_d.word = core_q.pend_word;
                core_d.ready = 1'b1;
                core_d.pend = 1'b0;
            end
            if (core_q.single) begin
                core_d.unread = 1'b0;
                core_d.rdy_latch = 1'b1;
                if (core_q.state == ST_SLEEP) begin
                    core_d.state = ST_SHUTDOWN;
                end
            end
        end

        unique case (core_q.state)
            ST_SHUTDOWN: begin
                // a select already low at release reaches the core as a fall
                // once it is through the synchroniser: two-wire use from power-up
                if (cs_fall && !core_q.unread) begin
                    core_d.state = ST_SETTLE;
                    core_d.timer = SETTLE_LOAD;
                    core_d.single = 1'b0;
                    core_d.drop = 1'b0;
                    core_d.rdy_latch = 1'b1;
                end else if (cs_fall) begin
                    // old single result still waiting to be read
                    core_d.rdy_latch = ~core_q.ready;
                end else if (cs_rise && core_q.reading) begin
                    core_d.reading = 1'b0;
                    core_d.ready = 1'b0;
                    core_d.unread = 1'b0;
                end
            end
            ST_SETTLE, ST_CONVERT: begin
                if (cs_fall) begin
                    core_d.rdy_latch = 1'b1;
                end
                if (cs_rise) begin
                    core_d.single = 1'b1;
                    if (core_q.ready || core_q.reading) begin
                        // ready data or a read in flight is thrown away
                        core_d.ready = 1'b0;
                        core_d.pend = 1'b0;
                        core_d.reading = 1'b0;
                        core_d.drop = 1'b1;
                    end
                end
                if (core_q.timer != '0) begin
                    core_d.timer = core_q.timer - 1'b1;
                end else if (core_q.state == ST_SETTLE) begin
                    core_d.state = ST_CONVERT;
                    core_d.timer = CONV_LOAD;
                end else if (core_d.single) begin
                    if (core_d.drop) begin
                        core_d.state = ST_SHUTDOWN;
                        core_d.drop = 1'b0;
                    end else begin
                        core_d.word = new_word;
                        core_d.ready = 1'b1;
                        core_d.unread = 1'b1;
                        core_d.state = ST_SLEEP;
                    end
                end else begin
                    core_d.timer = CONV_LOAD;
                    if (core_d.reading || start_ev) begin
                        // a word is going out, keep it stable
                        core_d.pend_word = new_word;
                        core_d.pend = 1'b1;
                    end else begin
                        core_d.word = new_word;
                        core_d.ready = 1'b1;
                    end
                end
            end
            ST_SLEEP: begin
                if (cs_fall) begin
                    // sampled only on a select fall, held while select stays low until a read finishes
                    core_d.rdy_latch = ~core_q.ready;
                end
                if (cs_rise && core_q.reading) begin
                    core_d.reading = 1'b0;
                    core_d.ready = 1'b0;
                    core_d.unread = 1'b0;
                    core_d.state = ST_SHUTDOWN;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_q <= '{
                state: ST_SHUTDOWN,
                timer: '0,
                cs_prev: CS_IDLE_RST,
                start_prev: 1'b0,
                done_prev: 1'b0,
                single: SINGLE_RST,
                drop: 1'b0,
                ready: 1'b0,
                unread: 1'b0,
                reading: 1'b0,
                rdy_latch: RDY_LATCH_RST,
                pend: 1'b0,
                word: '0,
                pend_word: '0
            };
        end else begin
            core_q <= core_d;
        end
    end

    // ---------------- pin ----------------

    logic ready_level;
    logic [FALL_CNT_W-1:0] bit_idx;

    // single mode shows the latched level, continuous the live one
    assign ready_level = core_q.single ? core_q.rdy_latch : ~core_q.ready;

    // falls 1..24 select bits 23..0; the 24th keeps the lsb up
    assign bit_idx = 5'(WORD_BITS) - shift_q.falls;

    always_comb begin
        if (shift_q.falls == FALL_IDLE) begin
            data_out_ready_pin_o = ready_level;
        end else begin
            data_out_ready_pin_o = core_q.word[bit_idx];
        end
    end

    // released straight from the pin, no clock needed
    assign data_out_ready_pin_oe_n = chip_select_n;

    assign converting = (core_q.state == ST_CONVERT);
    assign continuous_mode = ~core_q.single;
    assign in_shutdown = (core_q.state == ST_SHUTDOWN);
    assign result_valid = core_q.ready;

endmodule : asr_readout

`default_nettype wire

/* src/asr_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module asr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } asr_sync_state_t;

    asr_sync_state_t sync_q;
    asr_sync_state_t sync_d;

    initial begin
        if (WIDTH < 1) begin
            $error("asr_sync: WIDTH must be at least 1");
        end
    end

    // the first stage feeds only the second stage
    always_comb begin
        sync_d = sync_q;
        sync_d.meta = async_in;
        sync_d.stable = sync_q.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_q <= '0;
        end else begin
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q.stable;

endmodule : asr_sync

`default_nettype wire

/* tb/adc_serial_readout_ready_test.sv */
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin \
    check_count++; \
    if ((a) !== (b)) begin \
        fail_count++; \
        $display("[FAIL] %0t got %h exp %h", $time, a, b); \
    end \
end

module adc_serial_readout_ready_test;
    import asr_pkg::*;
    localparam int CONV = 200;
    localparam int SETTLE = 20;
    logic core_clk, reset_n, ul, oh, pin, last_q, pin_o, oe_n;
    logic conv, cont, shut, valid, cs_n, sclk, rdy;
    logic [CODE_BITS-1:0] code;
    logic [23:0] w, e;
    int fail_count, check_count, cyc, seed;

    asr_readout #(.CONV_CYCLES_P(CONV), .SETTLE_CYCLES_P(SETTLE)) asr_readout_i (
        .core_clk(core_clk), .reset_n(reset_n), .serial_clk(sclk), .chip_select_n(cs_n),
        .overflow_low_flag(ul), .overflow_high_flag(oh), .filter_code(code),
        .data_out_ready_pin_o(pin_o), .data_out_ready_pin_oe_n(oe_n), .converting(conv),
        .continuous_mode(cont), .in_shutdown(shut), .result_valid(valid));
    asr_host asr_host_i (.core_clk(core_clk), .pin(pin), .chip_select_n(cs_n),
        .serial_clk(sclk));

    // released pin shows the inverse so a stale bit never passes
    always_comb pin = oe_n ? ~last_q : pin_o;
    always @(posedge core_clk) if (!oe_n) last_q <= pin_o;

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            give_verdict();
        end
    end

    function automatic logic [23:0] exp_word(logic u, logic o, logic [CODE_BITS-1:0] c);
        return {u, o, c};
    endfunction : exp_word

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task automatic vals(input logic [23:0] v);
        @(negedge core_clk);
        ul = v[UNDERFLOW_POS];
        oh = v[OVERFLOW_POS];
        code = v[CODE_BITS-1:0];
        e = exp_word(ul, oh, code);
    endtask : vals

    task automatic wait_sig(ref logic s, input logic v);
        for (int i = 0; i < 3000 && s !== v; i++) @(negedge core_clk);
    endtask : wait_sig

    task automatic read_chk(input logic [23:0] x);
        asr_host_i.rd(25, 1'b0, rdy, w);
        `CHK(rdy, 1'b0)
        `CHK(w, x)
    endtask : read_chk

    initial begin
        logic [23:0] e2;
        reset_n = 1'b0;
        last_q = 1'b0;
        fail_count = 0;
        check_count = 0;
        cyc = 0;
        seed = $urandom(32'hECAB);
        ul = 1'($urandom);
        oh = 1'($urandom);
        code = CODE_BITS'($urandom);
        repeat (5) @(negedge core_clk);
        reset_n = 1'b1;
        vals(24'h3FFFFF);
        wait_sig(valid, 1'b1);
        `CHK(cont, 1'b1)
        vals(24'($urandom));
        repeat (5) @(negedge core_clk);
        `CHK(pin, 1'b0)
        e2 = e;
        repeat (CONV + 94) @(negedge core_clk);
        vals(24'($urandom));
        repeat (CONV - 110) @(negedge core_clk);
        // read spans a completion: old word, new ready after it
        read_chk(e2);
        repeat (6) @(negedge core_clk);
        `CHK(pin, 1'b0)
        read_chk(e);
        // the finished read clears ready a few edges late
        wait_sig(valid, 1'b0);
        wait_sig(valid, 1'b1);
        asr_host_i.sel(1'b1);
        repeat (6) @(negedge core_clk);
        `CHK(valid, 1'b0)
        `CHK(cont, 1'b0)
        wait_sig(shut, 1'b1);
        `CHK(shut, 1'b1)
        for (int k = 0; k < 3; k++) begin
            // last pass idles the serial clock high, changed while deselected
            if (k == 2)
                asr_host_i.idle(1'b1);
            vals(k == 0 ? 24'h800000 : 24'($urandom));
            asr_host_i.sel(1'b0);
            wait_sig(conv, 1'b1);
            repeat (20) @(negedge core_clk);
            asr_host_i.sel(1'b1);
            repeat (20) @(negedge core_clk);
            asr_host_i.sel(1'b0);
            repeat (6) @(negedge core_clk);
            `CHK(pin, 1'b1)
            wait_sig(valid, 1'b1);
            repeat (6) @(negedge core_clk);
            `CHK(pin, 1'b1)
            `CHK(conv, 1'b0)
            asr_host_i.sel(1'b1);
            asr_host_i.sel(1'b0);
            repeat (6) @(negedge core_clk);
            `CHK(conv, 1'b0)
            `CHK(pin, 1'b0)
            if (k == 0) begin
                read_chk(e);
                repeat (6) @(negedge core_clk);
                `CHK(pin, 1'b1)
                `CHK(shut, 1'b1)
                asr_host_i.sel(1'b1);
            end else begin
                // nine clocks, no byte multiple; then 24 clocks idling high
                asr_host_i.rd(k == 1 ? 9 : 24, k == 2, rdy, w);
                `CHK(rdy, 1'b0)
                if (k == 1)
                    `CHK(w[7:0], e[23:16])
                else
                    `CHK(w, e)
                asr_host_i.sel(1'b1);
                repeat (6) @(negedge core_clk);
                `CHK(valid, 1'b0)
                `CHK(shut, 1'b1)
            end
        end
        give_verdict();
    end
endmodule : adc_serial_readout_ready_test

`default_nettype wire

/* tb/asr_host.sv */
`timescale 1ns/10ps
`default_nettype none

module asr_host (
    input wire logic core_clk,
    input wire logic pin,
    output logic chip_select_n,
    output logic serial_clk
);
    // select low from power-up selects two-wire continuous use
    initial begin
        chip_select_n = 1'b0;
        serial_clk = 1'b0;
    end

    task automatic sel(input logic v);
        @(negedge core_clk);
        chip_select_n = v;
    endtask : sel

    // idle level may only change while deselected
    task automatic idle(input logic v);
        serial_clk = v;
    endtask : idle

    // clock stands still between frames; hi picks the idle-high port mode
    task automatic rd(input int n, input logic hi, output logic rdy, output logic [23:0] w);
        w = 24'h000000;
        #13;
        // ready tested before the first falling edge
        rdy = pin;
        for (int i = 0; i < n; i++) begin
            if (hi) begin
                #32 serial_clk = 1'b0;
                #32 serial_clk = 1'b1;
                w = {w[22:0], pin};
            end else begin
                #32 serial_clk = 1'b1;
                if (i == 0)
                    rdy = pin;
                else
                    w = {w[22:0], pin};
                #32 serial_clk = 1'b0;
            end
        end
    endtask : rd
endmodule : asr_host

`default_nettype wire

/* tb/asr_props.sv */
`timescale 1ns/10ps
`default_nettype none

module asr_props #(
    parameter int CONV_CYCLES_P = 200,
    parameter int SETTLE_CYCLES_P = 20
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic chip_select_n,
    input wire logic data_out_ready_pin_o,
    input wire logic data_out_ready_pin_oe_n,
    input wire logic converting,
    input wire logic continuous_mode,
    input wire logic in_shutdown,
    input wire logic result_valid
);
    logic [19:0] conv_q;
    logic [19:0] settle_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // run lengths of converting and of settling, zeroed on leaving
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_q <= 20'h00000;
            settle_q <= 20'h00000;
        end else begin
            conv_q <= converting ? conv_q + 20'h00001 : 20'h00000;
            settle_q <= (!converting && !in_shutdown && !result_valid) ?
                settle_q + 20'h00001 : 20'h00000;
        end
    end

    sequence held_select_s;
        (!chip_select_n)[*6];
    endsequence
    sequence single_done_s;
        $fell(converting) && !continuous_mode;
    endsequence

    pin_release_a: assert property (data_out_ready_pin_oe_n == chip_select_n)
        else $error("pin enable does not follow select");
    conv_length_a: assert property ($fell(converting) |-> conv_q >= CONV_CYCLES_P - 1)
        else $error("conversion cut short");
    settle_time_a: assert property ($rose(converting) && settle_q > 1 |->
        settle_q >= SETTLE_CYCLES_P - 1 && settle_q <= SETTLE_CYCLES_P + 1)
        else $error("settle time wrong");
    single_stop_a: assert property (single_done_s |=> (!converting)[*4])
        else $error("single mode restarted by itself");
    mode_switch_a: assert property ($rose(chip_select_n) && converting |->
        ##[1:5] !continuous_mode)
        else $error("select rise kept continuous mode");
    no_restart_a: assert property (!continuous_mode && result_valid && !converting
        |=> !converting)
        else $error("restart before result read");
    busy_latch_a: assert property ($fell(chip_select_n) && converting && !continuous_mode
        |-> ##4 data_out_ready_pin_o)
        else $error("busy not shown");
    ready_hold_a: assert property (held_select_s ##0 single_done_s
        |-> data_out_ready_pin_o[*3])
        else $error("single ready updated without select fall");
    cont_ready_a: assert property (continuous_mode && !chip_select_n && $rose(result_valid)
        |-> ##[0:4] !data_out_ready_pin_o)
        else $error("continuous ready not shown");
    discard_a: assert property ($rose(chip_select_n) && continuous_mode && result_valid
        |-> ##[2:5] !result_valid)
        else $error("data kept after select rise");
endmodule : asr_props

bind asr_readout asr_props #(.CONV_CYCLES_P(CONV_CYCLES_P), .SETTLE_CYCLES_P(SETTLE_CYCLES_P))
    asr_props_i (.core_clk, .reset_n, .chip_select_n, .data_out_ready_pin_o,
    .data_out_ready_pin_oe_n, .converting, .continuous_mode, .in_shutdown, .result_valid);

`default_nettype wire
